// >>> hw/pvic_defines.svh
/*
  constants of the pv input conditioning block: register offsets,
  reset values, limits and timing counts.
  assumes a 125 MHz clock and byte addresses on the register bus.
*/
`ifndef PVIC_DEFINES_SVH
`define PVIC_DEFINES_SVH

// ==========================================
// register byte offsets
`define PVIC_OFF_RANGE    6'h00
`define PVIC_OFF_SETUP    6'h04
`define PVIC_OFF_DROP     6'h08
`define PVIC_OFF_LO       6'h0C
`define PVIC_OFF_HI       6'h10
`define PVIC_OFF_RATIO    6'h14
`define PVIC_OFF_BIAS     6'h18
`define PVIC_OFF_FILT     6'h1C
`define PVIC_OFF_PV       6'h20
`define PVIC_OFF_STS      6'h24
`define PVIC_OFF_MSK      6'h28

// ==========================================
// reset values and limits (signed 16-bit counts, square root constants 20-bit)
`define PVIC_RST_SCALE_HI 16'h03E8
`define PVIC_RST_RATIO    16'h03E8
`define PVIC_VAL_MIN      16'hF831
`define PVIC_VAL_MAX      16'h270F
`define PVIC_RATIO_MIN    16'h0001
`define PVIC_DROP_MAX     16'h03E8
`define PVIC_FILT_MAX     16'h04B0
`define PVIC_PCT_FULL     16'h03E8
`define PVIC_PCT_HI_LIM   16'h044C
`define PVIC_PCT_LO_LIM   16'hFF9C
`define PVIC_DIV_1000     16'h03E8
`define PVIC_SQ_SCALE     20'h0_03E8
`define PVIC_SQ_ONE       20'h4_0000
`define PVIC_FRAC_BITS    8

// ==========================================
// range type codes
`define PVIC_TC_FIRST     7'h01
`define PVIC_TC_LAST      7'h1A
`define PVIC_RTD_FIRST    7'h29
`define PVIC_RTD_LAST     7'h44
`define PVIC_DC_FIRST     7'h51
`define PVIC_DC_LAST      7'h5A
`define PVIC_RANGE_LEGACY 7'h03
`define PVIC_RANGE_B_TC   7'h11
`define PVIC_B_TC_LOW_C   16'h0014

// ==========================================
// timing: sample period in ms and clock in kHz
`define PVIC_TS_MS        300
`define PVIC_CLK_KHZ      125000
`define PVIC_TS_CYCLES    (`PVIC_TS_MS * `PVIC_CLK_KHZ)
`define PVIC_TS_TENTHS    16'h0003

`endif

// >>> hw/pvic_pkg.sv
/*
  types of the pv input conditioning block: sequencer states and the
  complete state record of the core.
  assumes pvic_defines.svh for all numeric constants.
*/
`default_nettype none

package pvic_pkg;

   // ==========================================
   // sequencer, gray codes from idle through root, scale and ratio to filter
   typedef enum logic [2:0] {
      PVIC_IDLE  = 3'b000,
      PVIC_SQRT  = 3'b001,
      PVIC_SCALE = 3'b011,
      PVIC_RATIO = 3'b010,
      PVIC_FILT  = 3'b110
   } pvic_fsm_t;

   // ==========================================
   // all state of the core
   typedef struct packed {
      pvic_fsm_t          fsm;
      logic [31:0]        ts_cnt;
      logic               ack;
      logic [31:0]        rdata;
      logic [6:0]         rtype;
      logic               unit;
      logic               cjc_ext;
      logic [1:0]         dp;
      logic [15:0]        drop;
      logic signed [15:0] lo;
      logic signed [15:0] hi;
      logic signed [15:0] ratio;
      logic signed [15:0] bias;
      logic [15:0]        filt;
      logic [2:0]         sts;
      logic [2:0]         msk;
      logic signed [15:0] pct;
      logic signed [15:0] pv_scaled;
      logic signed [27:0] acc;
      logic signed [15:0] pv_out;
      logic               done;
      logic               hi_al;
      logic               lo_al;
      logic [19:0]        sq_op;
      logic [19:0]        sq_res;
      logic [19:0]        sq_one;
      logic               dv_busy;
      logic [5:0]         dv_cnt;
      logic [31:0]        dv_num;
      logic [16:0]        dv_rem;
      logic [15:0]        dv_den;
      logic               dv_neg;
   } pvic_state_t;

endpackage

`default_nettype wire

// >>> hw/pvic_core.sv
/*
  pv input conditioning core: square root with dropout, scaling,
  ratio and bias, first-order lag filter, limit alarms, avalon-mm
  register slave and a masked interrupt.
  assumes stage_input_i comes from converter logic on clk_i, in
  0.1 % of span, and range table limits arrive on range_tbl ports.
*/
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`include "pvic_defines.svh"
`default_nettype none

module pvic_core #(
   parameter int unsigned SAMPLE_CYCLES = `PVIC_TS_CYCLES
) (
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   input  wire logic [5:0]         avs_address_i,
   input  wire logic               avs_read_i,
   input  wire logic               avs_write_i,
   input  wire logic [31:0]        avs_writedata_i,
   output logic      [31:0]        avs_readdata_o,
   output logic                    avs_waitrequest_o,
   input  wire logic signed [15:0] stage_input_i,
   input  wire logic signed [15:0] range_tbl_low_i,
   input  wire logic signed [15:0] range_tbl_high_i,
   output logic signed [15:0]      stage_output_o,
   output logic                    result_valid_o,
   output logic      [1:0]         decimal_point_o,
   output logic                    temp_unit_o,
   output logic                    cjc_external_o,
   output logic                    high_limit_alarm_o,
   output logic                    low_limit_alarm_o,
   output logic                    irq_o
);

   // ==========================================
   // state record and reset image
   localparam pvic_pkg::pvic_state_t RST = '{
      fsm: pvic_pkg::PVIC_IDLE,
      hi: `PVIC_RST_SCALE_HI,
      ratio: `PVIC_RST_RATIO,
      default: '0
   };

   pvic_pkg::pvic_state_t q;
   pvic_pkg::pvic_state_t d;

   logic               is_tc;
   logic               is_rtd;
   logic               is_dc;
   logic               tick;
   logic               req;
   logic               wr_take;
   logic [2:0]         clr;
   logic [2:0]         set;
   logic signed [15:0] w16;
   logic signed [15:0] eff_lo;
   logic signed [15:0] eff_hi;
   logic signed [15:0] p;
   logic signed [31:0] quot;
   logic signed [31:0] dv_n;
   logic [15:0]        dv_d;
   logic               dv_load;
   logic [16:0]        rem_sh;
   logic [19:0]        sq_t;
   logic signed [27:0] comp_fx;

   function automatic logic in_val(input logic signed [15:0] v);
      in_val = (v >= $signed(`PVIC_VAL_MIN)) && (v <= $signed(`PVIC_VAL_MAX));
   endfunction

   // ==========================================
   // next state
   always_comb begin
      d       = q;
      d.done  = 1'b0;
      set     = 3'b000;
      clr     = 3'b000;
      dv_load = 1'b0;
      dv_n    = '0;
      dv_d    = `PVIC_DIV_1000;
      comp_fx = '0;
      p       = stage_input_i;
      w16     = avs_writedata_i[15:0];
      is_tc   = (q.rtype >= `PVIC_TC_FIRST) && (q.rtype <= `PVIC_TC_LAST);
      is_rtd  = (q.rtype >= `PVIC_RTD_FIRST) && (q.rtype <= `PVIC_RTD_LAST);
      is_dc   = (q.rtype >= `PVIC_DC_FIRST) && (q.rtype <= `PVIC_DC_LAST);

      // table limits for sensor ranges, b type floor in celsius
      eff_lo = is_dc ? q.lo : range_tbl_low_i;
      eff_hi = is_dc ? q.hi : range_tbl_high_i;
      if ((q.rtype == `PVIC_RANGE_B_TC) && !q.unit) begin
         eff_lo = `PVIC_B_TC_LOW_C;
      end

      // sample period divider
      tick = (q.ts_cnt == 32'(SAMPLE_CYCLES - 1));
      d.ts_cnt = tick ? 32'h0000_0000 : q.ts_cnt + 32'h0000_0001;

      // bus: first cycle stalls and latches read data, second completes
      req     = avs_read_i | avs_write_i;
      wr_take = avs_write_i & q.ack;
      d.ack   = req & ~q.ack;
      if (req && !q.ack && avs_read_i) begin
         case (avs_address_i)
            `PVIC_OFF_RANGE: d.rdata = {25'h000_0000, q.rtype};
            `PVIC_OFF_SETUP: d.rdata = {28'h000_0000, q.dp, q.cjc_ext, q.unit};
            `PVIC_OFF_DROP:  d.rdata = {16'h0000, q.drop};
            `PVIC_OFF_LO:    d.rdata = 32'(q.lo);
            `PVIC_OFF_HI:    d.rdata = 32'(q.hi);
            `PVIC_OFF_RATIO: d.rdata = 32'(q.ratio);
            `PVIC_OFF_BIAS:  d.rdata = 32'(q.bias);
            `PVIC_OFF_FILT:  d.rdata = {16'h0000, q.filt};
            `PVIC_OFF_PV:    d.rdata = 32'(q.pv_out);
            `PVIC_OFF_STS:   d.rdata = {26'h000_0000, q.lo_al, q.hi_al, 1'b0, q.sts};
            `PVIC_OFF_MSK:   d.rdata = {29'h0000_0000, q.msk};
            default:         d.rdata = 32'h0000_0000;
         endcase
      end
      if (wr_take) begin
         case (avs_address_i)
            `PVIC_OFF_RANGE: d.rtype = avs_writedata_i[6:0];
            `PVIC_OFF_SETUP: begin
               if (is_tc || is_rtd) begin
                  d.unit = avs_writedata_i[0];
               end
               if (is_tc) begin
                  d.cjc_ext = avs_writedata_i[1];
               end
               d.dp = avs_writedata_i[3:2];
            end
            `PVIC_OFF_DROP: begin
               if (is_dc && !w16[15] && (w16 <= $signed(`PVIC_DROP_MAX))) begin
                  d.drop = w16;
               end
            end
            `PVIC_OFF_LO: begin
               if (is_dc && in_val(w16)) begin
                  d.lo = w16;
               end
            end
            `PVIC_OFF_HI: begin
               if (is_dc && in_val(w16)) begin
                  d.hi = w16;
               end
            end
            `PVIC_OFF_RATIO: begin
               if ((w16 >= $signed(`PVIC_RATIO_MIN)) && (w16 <= $signed(`PVIC_VAL_MAX))) begin
                  d.ratio = w16;
               end
            end
            `PVIC_OFF_BIAS: begin
               if (in_val(w16)) begin
                  d.bias = w16;
               end
            end
            `PVIC_OFF_FILT: begin
               if (!w16[15] && (w16 <= $signed(`PVIC_FILT_MAX))) begin
                  d.filt = w16;
               end
            end
            `PVIC_OFF_STS: clr = avs_writedata_i[2:0];
            `PVIC_OFF_MSK: d.msk = avs_writedata_i[2:0];
            default: ;
         endcase
      end
      if (d.rtype == `PVIC_RANGE_LEGACY) begin
         d.dp = 2'b00;
      end

      // shared restoring divider, one quotient bit a cycle
      rem_sh = {q.dv_rem[15:0], q.dv_num[31]};
      quot   = q.dv_neg ? -$signed(q.dv_num) : $signed(q.dv_num);
      if (q.dv_busy && (q.dv_cnt != 6'h00)) begin
         d.dv_cnt = q.dv_cnt - 6'h01;
         if (rem_sh >= {1'b0, q.dv_den}) begin
            d.dv_rem = rem_sh - {1'b0, q.dv_den};
            d.dv_num = {q.dv_num[30:0], 1'b1};
         end else begin
            d.dv_rem = rem_sh;
            d.dv_num = {q.dv_num[30:0], 1'b0};
         end
      end

      sq_t = q.sq_res + q.sq_one;

      // sequence: root, scale, ratio and bias, filter
      case (q.fsm)
         pvic_pkg::PVIC_IDLE: begin
            if (tick) begin
               d.pct   = p;
               d.hi_al = p > $signed(`PVIC_PCT_HI_LIM);
               d.lo_al = p < $signed(`PVIC_PCT_LO_LIM);
               set[1]  = d.hi_al & ~q.hi_al;
               set[2]  = d.lo_al & ~q.lo_al;
               d.fsm   = pvic_pkg::PVIC_SCALE;
               if (is_dc && (q.drop != 16'h0000) && (p > 16'sh0000) &&
                   (p < $signed(`PVIC_PCT_FULL))) begin
                  if (p < $signed(q.drop)) begin
                     d.pct = 16'sh0000;
                  end else begin
                     d.sq_op  = 20'(p[9:0] * `PVIC_SQ_SCALE);
                     d.sq_res = 20'h0_0000;
                     d.sq_one = `PVIC_SQ_ONE;
                     d.fsm    = pvic_pkg::PVIC_SQRT;
                  end
               end
            end
         end
         pvic_pkg::PVIC_SQRT: begin
            if (q.sq_one == 20'h0_0000) begin
               d.pct = 16'(q.sq_res);
               d.fsm = pvic_pkg::PVIC_SCALE;
            end else begin
               d.sq_one = q.sq_one >> 2;
               if (q.sq_op >= sq_t) begin
                  d.sq_op  = q.sq_op - sq_t;
                  d.sq_res = (q.sq_res >> 1) + q.sq_one;
               end else begin
                  d.sq_res = q.sq_res >> 1;
               end
            end
         end
         pvic_pkg::PVIC_SCALE: begin
            dv_n = 32'((eff_hi - eff_lo) * q.pct);
            if (!q.dv_busy) begin
               dv_load = 1'b1;
            end else if (q.dv_cnt == 6'h00) begin
               d.pv_scaled = 16'(eff_lo + quot);
               d.dv_busy   = 1'b0;
               d.fsm       = pvic_pkg::PVIC_RATIO;
            end
         end
         pvic_pkg::PVIC_RATIO: begin
            dv_n = q.pv_scaled * q.ratio;
            if (!q.dv_busy) begin
               dv_load = 1'b1;
            end else if (q.dv_cnt == 6'h00) begin
               d.pv_scaled = 16'(quot + q.bias);
               d.dv_busy   = 1'b0;
               d.fsm       = pvic_pkg::PVIC_FILT;
            end
         end
         pvic_pkg::PVIC_FILT: begin
            // eight fraction bits keep slow filters from sticking
            comp_fx = 28'(q.pv_scaled) <<< `PVIC_FRAC_BITS;
            dv_n    = 32'((comp_fx - q.acc) * 3);
            dv_d    = q.filt + `PVIC_TS_TENTHS;
            if (q.filt == 16'h0000) begin
               d.acc = comp_fx;
            end else if (!q.dv_busy) begin
               dv_load = 1'b1;
            end else if (q.dv_cnt == 6'h00) begin
               d.acc = q.acc + 28'(quot);
            end
            if ((q.filt == 16'h0000) || (q.dv_busy && (q.dv_cnt == 6'h00))) begin
               d.pv_out  = 16'(d.acc >>> `PVIC_FRAC_BITS);
               d.done    = 1'b1;
               set[0]    = 1'b1;
               d.dv_busy = 1'b0;
               d.fsm     = pvic_pkg::PVIC_IDLE;
            end
         end
         default: d.fsm = pvic_pkg::PVIC_IDLE;
      endcase

      if (dv_load) begin
         d.dv_busy = 1'b1;
         d.dv_cnt  = 6'h20;
         d.dv_neg  = dv_n[31];
         d.dv_num  = dv_n[31] ? 32'(-dv_n) : dv_n;
         d.dv_rem  = 17'h0_0000;
         d.dv_den  = dv_d;
      end

      // set wins over a clear in the same cycle
      d.sts = (q.sts & ~clr) | set;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= RST;
      end else begin
         q <= d;
      end
   end

   // ==========================================
   // outputs
   assign avs_waitrequest_o  = req & ~q.ack;
   assign avs_readdata_o     = q.rdata;
   assign stage_output_o     = q.pv_out;
   assign result_valid_o     = q.done;
   assign decimal_point_o    = q.dp;
   assign temp_unit_o        = q.unit;
   assign cjc_external_o     = q.cjc_ext;
   assign high_limit_alarm_o = q.hi_al;
   assign low_limit_alarm_o  = q.lo_al;
   assign irq_o              = |(q.sts & q.msk);

   // ==========================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   AST_DP_LEGACY: assert property (q.rtype == `PVIC_RANGE_LEGACY |-> decimal_point_o == 2'b00)
      else $error("decimal point not zero on legacy range");
   AST_RATIO_RANGE: assert property ((q.ratio >= 16'sh0001) && (q.ratio <= 16'sh270F))
      else $error("ratio out of range");
   AST_SCALE_RANGE: assert property (in_val(q.lo) && in_val(q.hi))
      else $error("scaling limit out of range");
   AST_FILT_RANGE: assert property (q.filt <= 16'h04B0)
      else $error("filter constant out of range");
   AST_DROP_LOCK: assert property (wr_take && (avs_address_i == `PVIC_OFF_DROP) && !is_dc
                                   |=> $stable(q.drop))
      else $error("dropout written on non-dc range");
   AST_UNIT_LOCK: assert property (wr_take && (avs_address_i == `PVIC_OFF_SETUP) && !is_tc && !is_rtd
                                   |=> $stable(temp_unit_o))
      else $error("unit written on dc range");
   AST_HI_ALARM: assert property ((q.fsm == pvic_pkg::PVIC_IDLE) && tick && (p > 16'sh044C)
                                  |=> high_limit_alarm_o && !low_limit_alarm_o)
      else $error("high alarm missing");
   AST_LO_ALARM: assert property ((q.fsm == pvic_pkg::PVIC_IDLE) && tick && (p < 16'shFF9C)
                                  |=> low_limit_alarm_o && !high_limit_alarm_o)
      else $error("low alarm missing");
   AST_DROPOUT: assert property ((q.fsm == pvic_pkg::PVIC_IDLE) && tick && is_dc && (q.drop != 16'h0000)
                                 && (p > 16'sh0000) && (p < $signed(q.drop))
                                 |=> (q.pct == 16'sh0000) && (q.fsm == pvic_pkg::PVIC_SCALE))
      else $error("dropout did not force zero");
   AST_PASS: assert property ((q.fsm == pvic_pkg::PVIC_IDLE) && tick
                              && ((p <= 16'sh0000) || (p >= 16'sh03E8))
                              |=> (q.pct == $past(p)) && (q.fsm == pvic_pkg::PVIC_SCALE))
      else $error("pass through altered input");
   AST_SQRT_TIME: assert property ($rose(q.fsm == pvic_pkg::PVIC_SQRT)
                                   |-> ##[10:11] q.fsm == pvic_pkg::PVIC_SCALE)
      else $error("root did not finish in time");
   AST_RESULT: assert property ((q.fsm == pvic_pkg::PVIC_IDLE) && tick |-> ##[3:160] result_valid_o)
      else $error("no result for sample");
   AST_VALID_PULSE: assert property (result_valid_o |=> !result_valid_o)
      else $error("result strobe longer than one cycle");
   AST_FILT_OFF: assert property ((q.fsm == pvic_pkg::PVIC_FILT) && (q.filt == 16'h0000)
                                  |=> result_valid_o && (stage_output_o == $past(q.pv_scaled)))
      else $error("unfiltered result differs from compensated pv");
   AST_B_TC_FLOOR: assert property ((q.rtype == `PVIC_RANGE_B_TC) && !q.unit |-> eff_lo == 16'sh0014)
      else $error("b thermocouple floor not applied");
   AST_TABLE_LIMITS: assert property (!is_dc && (q.rtype != `PVIC_RANGE_B_TC)
                                      |-> (eff_lo == range_tbl_low_i) && (eff_hi == range_tbl_high_i))
      else $error("sensor range not using table limits");
   AST_BUS: assert property (req && !q.ack |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("bus answer not in two cycles");
   AST_STS_SET_WINS: assert property (set[0] && wr_take && (avs_address_i == `PVIC_OFF_STS) |=> q.sts[0])
      else $error("status clear beat a new event");

endmodule // pvic_core

`default_nettype wire

// >>> verification/pvic_front_model.sv
/*
  model of the analog front end and converter feeding the pv input
  conditioning core: percent-of-span samples and range table limits.
  assumes the bench sets the analog level and table limits on clk_i.
*/
`default_nettype none

module pvic_front_model (
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   input  wire logic signed [15:0] pct_i,
   input  wire logic signed [15:0] tbl_lo_i,
   input  wire logic signed [15:0] tbl_hi_i,
   output logic signed [15:0]      stage_input_o,
   output logic signed [15:0]      range_low_o,
   output logic signed [15:0]      range_high_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================
   // converter result lands one clock after the analog level settles
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stage_input_o <= 16'h0000;
         range_low_o   <= 16'h0000;
         range_high_o  <= 16'h0000;
      end else begin
         stage_input_o <= pct_i;
         range_low_o   <= tbl_lo_i;
         range_high_o  <= tbl_hi_i;
      end
   end

endmodule // pvic_front_model

`default_nettype wire

// >>> verification/tb_pv_input_conditioning.sv
/*
  self-checking bench of the pv input conditioning core: avalon-mm
  register tasks and sample sequences with expected values.
  assumes pvic_defines.svh and a shortened sample period.
*/
`include "pvic_defines.svh"
`default_nettype none

module tb_pv_input_conditioning;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned SC = 200;
   logic clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
   logic [5:0] avs_address_i = 6'h00;
   logic [31:0] avs_writedata_i = 32'h0000_0000, avs_readdata_o, q;
   logic avs_waitrequest_o, result_valid_o, temp_unit_o, cjc_external_o, irq_o;
   logic high_limit_alarm_o, low_limit_alarm_o;
   logic [1:0] decimal_point_o;
   logic signed [15:0] pct_q = 16'h0000, stage_input, tbl_lo, tbl_hi, stage_output_o;
   int n_mismatch = 0, compares = 0, cyc = 0;
   int pcts [6] = '{100, 99, 360, 1000, 0, -50};
   int roots [6] = '{316, 0, 600, 1000, 0, -50};

   always #4 clk_i = ~clk_i;

   pvic_core #(.SAMPLE_CYCLES(SC)) i_pvic_core (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .stage_input_i(stage_input), .range_tbl_low_i(tbl_lo),
      .range_tbl_high_i(tbl_hi), .stage_output_o(stage_output_o), .result_valid_o(result_valid_o),
      .decimal_point_o(decimal_point_o), .temp_unit_o(temp_unit_o), .cjc_external_o(cjc_external_o),
      .high_limit_alarm_o(high_limit_alarm_o), .low_limit_alarm_o(low_limit_alarm_o), .irq_o(irq_o));

   pvic_front_model i_pvic_front_model (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .pct_i(pct_q), .tbl_lo_i(16'hFF9C), .tbl_hi_i(16'h0190),
      .stage_input_o(stage_input), .range_low_o(tbl_lo), .range_high_o(tbl_hi));

   // ==========================================
   // verdict and hang guard
   task automatic give_verdict();
      if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // ==========================================
   // avalon-mm master: waitrequest and read data taken at the rising edge itself
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= !w;
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 100);
      q = avs_readdata_o;
      if (n >= 100) chk(1'b1, 1'b0, "bus hang");
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdc(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(q, e, "register read");
   endtask

   task automatic wait_res();
      int n;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (result_valid_o !== 1'b1 && n < 1000);
      if (n >= 1000) chk(1'b1, 1'b0, "no result");
      @(posedge clk_i);
   endtask

   // input changed just after a result so the next tick sees it
   task automatic smp(input logic signed [15:0] v, input logic [31:0] e);
      wait_res();
      pct_q <= v;
      wait_res();
      chk({{16{stage_output_o[15]}}, stage_output_o}, e, "pv result");
   endtask

   // ==========================================
   // main sequence
   initial begin
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      rdc(`PVIC_OFF_RANGE, 32'h0000_0000);
      rdc(`PVIC_OFF_SETUP, 32'h0000_0000);
      rdc(`PVIC_OFF_DROP, 32'h0000_0000);
      rdc(`PVIC_OFF_LO, 32'h0000_0000);
      rdc(`PVIC_OFF_HI, 32'h0000_03E8);
      rdc(`PVIC_OFF_RATIO, 32'h0000_03E8);
      rdc(`PVIC_OFF_BIAS, 32'h0000_0000);
      rdc(`PVIC_OFF_FILT, 32'h0000_0000);
      rdc(6'h3C, 32'h0000_0000);
      wr(`PVIC_OFF_RANGE, 32'h0000_0051);
      wr(`PVIC_OFF_SETUP, 32'h0000_0003);
      chk({cjc_external_o, temp_unit_o}, 2'b00, "setup on dc range");
      wr(`PVIC_OFF_RANGE, 32'h0000_0029);
      wr(`PVIC_OFF_SETUP, 32'h0000_0003);
      chk({cjc_external_o, temp_unit_o}, 2'b01, "setup on rtd range");
      wr(`PVIC_OFF_RANGE, 32'h0000_0005);
      wr(`PVIC_OFF_SETUP, 32'h0000_0003);
      chk({cjc_external_o, temp_unit_o}, 2'b11, "setup on tc range");
      wr(`PVIC_OFF_LO, 32'h0000_0005);
      rdc(`PVIC_OFF_LO, 32'h0000_0000);
      wr(`PVIC_OFF_DROP, 32'h0000_0064);
      rdc(`PVIC_OFF_DROP, 32'h0000_0000);
      smp(16'sd500, 32'd150);
      wr(`PVIC_OFF_SETUP, 32'h0000_0000);
      wr(`PVIC_OFF_RANGE, 32'h0000_0011);
      smp(16'sd500, 32'd210);
      wr(`PVIC_OFF_RANGE, 32'h0000_0051);
      wr(`PVIC_OFF_SETUP, 32'h0000_000C);
      chk(decimal_point_o, 2'd3, "decimal point");
      wr(`PVIC_OFF_RANGE, 32'h0000_0003);
      wr(`PVIC_OFF_SETUP, 32'h0000_0008);
      chk(decimal_point_o, 2'd0, "legacy range point");
      wr(`PVIC_OFF_RANGE, 32'h0000_0051);
      wr(`PVIC_OFF_LO, 32'hFFFF_F831);
      wr(`PVIC_OFF_HI, 32'h0000_270F);
      wr(`PVIC_OFF_LO, 32'hFFFF_F830);
      rdc(`PVIC_OFF_LO, 32'hFFFF_F831);
      wr(`PVIC_OFF_RATIO, 32'h0000_2710);
      wr(`PVIC_OFF_RATIO, 32'h0000_0000);
      rdc(`PVIC_OFF_RATIO, 32'h0000_03E8);
      wr(`PVIC_OFF_RATIO, 32'h0000_07D0);
      wr(`PVIC_OFF_BIAS, 32'hFFFF_FFF6);
      smp(16'sd500, 32'd7990);
      wr(`PVIC_OFF_RATIO, 32'h0000_03E8);
      wr(`PVIC_OFF_BIAS, 32'h0000_0000);
      wr(`PVIC_OFF_LO, 32'h0000_0000);
      wr(`PVIC_OFF_HI, 32'h0000_03E8);
      wr(`PVIC_OFF_DROP, 32'h0000_03E9);
      wr(`PVIC_OFF_DROP, 32'h0000_0064);
      rdc(`PVIC_OFF_DROP, 32'h0000_0064);
      foreach (pcts[i]) smp(16'(pcts[i]), 32'(roots[i]));
      wr(`PVIC_OFF_DROP, 32'h0000_0000);
      wr(`PVIC_OFF_STS, 32'h0000_0007);
      wr(`PVIC_OFF_MSK, 32'h0000_0002);
      smp(16'sd1100, 32'd1100);
      chk({high_limit_alarm_o, irq_o}, 2'b00, "no alarm at limit");
      smp(16'sd1101, 32'd1101);
      chk({high_limit_alarm_o, irq_o}, 2'b11, "high alarm");
      rdc(`PVIC_OFF_STS, 32'h0000_0013);
      wr(`PVIC_OFF_STS, 32'h0000_0002);
      chk(irq_o, 1'b0, "irq cleared");
      smp(-16'sd101, -32'sd101);
      chk({high_limit_alarm_o, low_limit_alarm_o}, 2'b01, "low alarm");
      wr(`PVIC_OFF_MSK, 32'h0000_0004);
      chk(irq_o, 1'b1, "low alarm irq");
      wr(`PVIC_OFF_STS, 32'h0000_0004);
      chk(irq_o, 1'b0, "low irq cleared");
      wr(`PVIC_OFF_FILT, 32'h0000_04B1);
      rdc(`PVIC_OFF_FILT, 32'h0000_0000);
      wr(`PVIC_OFF_FILT, 32'h0000_04B0);
      rdc(`PVIC_OFF_FILT, 32'h0000_04B0);
      wr(`PVIC_OFF_FILT, 32'h0000_0003);
      // settle from above so truncation leaves the filter at zero
      pct_q <= 16'sd1000;
      repeat (24) wait_res();
      pct_q <= 16'sd0;
      repeat (24) wait_res();
      smp(16'sd1000, 32'd500);
      wait_res();
      chk({{16{stage_output_o[15]}}, stage_output_o}, 32'd750, "filter second step");
      give_verdict();
   end

endmodule // tb_pv_input_conditioning

`default_nettype wire
